// file: hw/ecd_clk_div.v
// Power-of-two divider and gate for one output clock
module ecd_clk_div #(
    parameter CW = 14                // Counter width, largest exponent
) (
    input  wire       clock,         // System clock
    input  wire       reset,         // Synchronous reset, active high
    input  wire       srcLevel,      // Synchronised source level
    input  wire       srcRise,       // One-cycle pulse per source rise
    input  wire       gateOn,        // Enable and legal setting
    input  wire [3:0] expSel,        // Division exponent
    output reg        divClk         // Divided, gated clock
);

    reg [CW-1:0] countQ;
    reg          tapD;

    // Counter of source rises, parked at zero while gated off
    always @(posedge clock)
    begin
        if (reset || !gateOn)
            countQ <= {CW{1'b0}};
        else if (srcRise)
            countQ <= countQ + {{(CW-1){1'b0}}, 1'b1};
    end

    // Exponent zero passes the source through undivided
    always @*
    begin
        tapD = 1'b0;
        if (expSel == 4'h0)
            tapD = srcLevel;
        else if (expSel <= CW)
            tapD = countQ[expSel - 4'h1];
    end

    // Gated output rests low; a divided tap starts low, but exponent zero passes a high source level at once
    always @(posedge clock)
    begin
        if (reset || !gateOn)
            divClk <= 1'b0;
        else
            divClk <= tapD;
    end

endmodule // ecd_clk_div

// file: hw/ecd_clock_ctrl.v
// Source select, division and gating for the display timing/doubler clocks
//
// What this block does
// - The timing clock source comes from a 2-bit field: 0 fast osc B, 1 slow osc, 2 fast osc A, 3 reserved, reset 0.
// - The timing clock divides by 1/128..1/16384 for a fast source and 1/1..1/128 for the slow one, by a 3-bit code.
// - The divided timing clock is delivered only while its enable bit 0 is set, which resets to zero.
// - The doubler clock source uses the same 2-bit encoding and resets to zero.
// - The doubler ratio field resets to zero; for a fast source codes 0, 1 and 7 are reserved, 2 to 6 give 1/16, 1/32, 1/64 up to 1/256.
// - The divided doubler clock is delivered only while its enable bit is set, which resets to zero.
`include "ecd_defs.vh"
module ecd_clock_ctrl #(
    parameter AW = 16,                   // Register address width
    parameter DW = 8                     // Register data width
) (
    input  wire          clock,          // System clock, 40 MHz
    input  wire          reset,          // Synchronous reset, active high
    input  wire [AW-1:0] regAddr,        // Register address
    input  wire [DW-1:0] regWrData,      // Register write data
    input  wire          regWrStb,       // Write strobe, one cycle
    input  wire          regRdStb,       // Read strobe, one cycle
    output reg  [DW-1:0] regRdData,      // Read data, cycle after strobe
    input  wire          fastOscB,       // Fast oscillator B pin
    input  wire          fastOscA,       // Fast oscillator A pin
    input  wire          slowOsc,        // Slow oscillator pin
    output wire          timingClkOut,   // Divided timing clock
    output wire          doublerClkOut   // Divided doubler clock
);

    // Control fields of the timing clock register
    reg       timingGateOnQ;
    reg [1:0] timingSrcSelQ;
    reg [2:0] timingDivSelQ;

    // Control fields of the doubler clock register
    reg       doublerGateOnQ;
    reg [1:0] doublerSrcSelQ;
    reg [2:0] doublerDivSelQ;

    // Synchronised oscillator levels and edge history
    wire [2:0] oscPin;
    wire [2:0] oscSync;
    reg  [2:0] oscPrevQ;
    wire [2:0] oscRise;

    // Per-clock source selection and legality
    reg        timingLevel;
    reg        timingRise;
    reg  [3:0] timingExp;
    reg        timingLegal;
    reg        doublerLevel;
    reg        doublerRise;
    reg  [3:0] doublerExp;
    reg        doublerLegal;
    reg        doublerRatioOk;

    reg  [DW-1:0] rdDataD;

    // Pin order in the vector follows the source code order
    assign oscPin = {fastOscA, slowOsc, fastOscB};

    // Oscillators are foreign clocks, so each passes two flops
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : gSync
            ecd_sync uSync (
                .clock   (clock),
                .reset   (reset),
                .asyncIn (oscPin[gi]),
                .syncOut (oscSync[gi])
            );
        end
    endgenerate

    // Edge history taken from the synchronised level only
    always @(posedge clock)
    begin
        if (reset)
            oscPrevQ <= 3'h0;
        else
            oscPrevQ <= oscSync;
    end

    assign oscRise = oscSync & ~oscPrevQ;

    // Register writes; reserved bits are simply not stored
    always @(posedge clock)
    begin
        if (reset)
        begin
            timingGateOnQ  <= `ECD_EN_RST;
            timingSrcSelQ  <= `ECD_SRC_RST;
            timingDivSelQ  <= `ECD_DIV_RST;
            doublerGateOnQ <= `ECD_EN_RST;
            doublerSrcSelQ <= `ECD_SRC_RST;
            doublerDivSelQ <= `ECD_DIV_RST;
        end
        else if (regWrStb)
        begin
            if (regAddr == `ECD_TCLK_OFFSET)
            begin
                timingGateOnQ <= regWrData[`ECD_EN_BIT];
                timingSrcSelQ <= regWrData[`ECD_SRC_MSB:`ECD_SRC_LSB];
                timingDivSelQ <= regWrData[`ECD_DIV_MSB:`ECD_DIV_LSB];
            end
            else if (regAddr == `ECD_DCLK_OFFSET)
            begin
                doublerGateOnQ <= regWrData[`ECD_EN_BIT];
                doublerSrcSelQ <= regWrData[`ECD_SRC_MSB:`ECD_SRC_LSB];
                doublerDivSelQ <= regWrData[`ECD_DIV_MSB:`ECD_DIV_LSB];
            end
        end
    end

    always @*
    begin
        timingLevel = 1'b0;
        timingRise  = 1'b0;
        timingLegal = 1'b1;
        case (timingSrcSelQ)
            `ECD_SRC_FAST_B:
            begin
                timingLevel = oscSync[0];
                timingRise  = oscRise[0];
            end
            `ECD_SRC_SLOW:
            begin
                timingLevel = oscSync[1];
                timingRise  = oscRise[1];
            end
            `ECD_SRC_FAST_A:
            begin
                timingLevel = oscSync[2];
                timingRise  = oscRise[2];
            end
            default:
                timingLegal = 1'b0;
        endcase
    end

    // timing exponent, fast sources start at 1/128
    always @*
    begin
        if (timingSrcSelQ == `ECD_SRC_SLOW)
            timingExp = {1'b0, timingDivSelQ};
        else
            timingExp = `ECD_TCLK_FAST_BASE + {1'b0, timingDivSelQ};
    end

    always @*
    begin
        doublerLevel = 1'b0;
        doublerRise  = 1'b0;
        doublerLegal = 1'b1;
        case (doublerSrcSelQ)
            `ECD_SRC_FAST_B:
            begin
                doublerLevel = oscSync[0];
                doublerRise  = oscRise[0];
            end
            `ECD_SRC_SLOW:
            begin
                doublerLevel = oscSync[1];
                doublerRise  = oscRise[1];
            end
            `ECD_SRC_FAST_A:
            begin
                doublerLevel = oscSync[2];
                doublerRise  = oscRise[2];
            end
            default:
                doublerLegal = 1'b0;
        endcase
    end

    // doubler exponent; code 2 on a fast source is 1/16
    // Ratio legality kept apart so each flag has a single driver
    always @*
    begin
        doublerExp     = {1'b0, doublerDivSelQ};
        doublerRatioOk = 1'b1;
        if (doublerSrcSelQ == `ECD_SRC_SLOW)
        begin
            // slow source above 1/8 is reserved
            if (doublerDivSelQ > `ECD_DCLK_SLOW_MAX)
                doublerRatioOk = 1'b0;
        end
        else
        begin
            doublerExp = `ECD_DCLK_FAST_BASE + {1'b0, doublerDivSelQ};
            // fast codes outside 2..6 are reserved
            if (doublerDivSelQ < `ECD_DCLK_FAST_MIN
                || doublerDivSelQ > `ECD_DCLK_FAST_MAX)
                doublerRatioOk = 1'b0;
        end
    end

    // timing clock gated by enable and legal source
    ecd_clk_div #(
        .CW (14)
    ) uTimingDiv (
        .clock    (clock),
        .reset    (reset),
        .srcLevel (timingLevel),
        .srcRise  (timingRise),
        .gateOn   (timingGateOnQ && timingLegal),
        .expSel   (timingExp),
        .divClk   (timingClkOut)
    );

    // doubler clock gated by enable and legal setting
    ecd_clk_div #(
        .CW (14)
    ) uDoublerDiv (
        .clock    (clock),
        .reset    (reset),
        .srcLevel (doublerLevel),
        .srcRise  (doublerRise),
        .gateOn   (doublerGateOnQ && doublerLegal && doublerRatioOk),
        .expSel   (doublerExp),
        .divClk   (doublerClkOut)
    );

    // Read mux; unmapped offsets and reserved bits read zero
    always @*
    begin
        rdDataD = {DW{1'b0}};
        if (regAddr == `ECD_TCLK_OFFSET)
        begin
            rdDataD[`ECD_EN_BIT]                 = timingGateOnQ;
            rdDataD[`ECD_SRC_MSB:`ECD_SRC_LSB]   = timingSrcSelQ;
            rdDataD[`ECD_DIV_MSB:`ECD_DIV_LSB]   = timingDivSelQ;
        end
        else if (regAddr == `ECD_DCLK_OFFSET)
        begin
            rdDataD[`ECD_EN_BIT]                 = doublerGateOnQ;
            rdDataD[`ECD_SRC_MSB:`ECD_SRC_LSB]   = doublerSrcSelQ;
            rdDataD[`ECD_DIV_MSB:`ECD_DIV_LSB]   = doublerDivSelQ;
        end
        else if (regAddr == `ECD_STATUS_OFFSET)
        begin
            // Shows whether each clock is actually running
            rdDataD[`ECD_STAT_TCLK_BIT] = timingGateOnQ && timingLegal;
            rdDataD[`ECD_STAT_DCLK_BIT] = doublerGateOnQ && doublerLegal
                                          && doublerRatioOk;
        end
    end

    // Read data stands for one cycle only, zero otherwise
    always @(posedge clock)
    begin
        if (reset)
            regRdData <= {DW{1'b0}};
        else if (regRdStb)
            regRdData <= rdDataD;
        else
            regRdData <= {DW{1'b0}};
    end

endmodule // ecd_clock_ctrl

// file: hw/ecd_sync.v
// Two-stage synchroniser for one oscillator pin
module ecd_sync (
    input  wire clock,    // System clock
    input  wire reset,    // Synchronous reset, active high
    input  wire asyncIn,  // Pin from another clock domain
    output reg  syncOut   // Level safe to use in this domain
);

    reg stage1Q;

    // First stage is read by the second stage only
    always @(posedge clock)
    begin
        if (reset)
        begin
            stage1Q <= 1'b0;
            syncOut <= 1'b0;
        end
        else
        begin
            stage1Q <= asyncIn;
            syncOut <= stage1Q;
        end
    end

endmodule // ecd_sync

// file: pkg/ecd_defs.vh
// Register map, field layout and codes for the display clock control block
`ifndef ECD_DEFS_VH
`define ECD_DEFS_VH

// Register offsets
`define ECD_TCLK_OFFSET     16'h5070
`define ECD_DCLK_OFFSET     16'h5071
`define ECD_STATUS_OFFSET   16'h507F

// Field positions shared by both control registers
`define ECD_EN_BIT          0
`define ECD_SRC_LSB         2
`define ECD_SRC_MSB         3
`define ECD_DIV_LSB         4
`define ECD_DIV_MSB         6

// Reset values of the fields
`define ECD_EN_RST          1'h0
`define ECD_SRC_RST         2'h0
`define ECD_DIV_RST         3'h0

// Source select codes
`define ECD_SRC_FAST_B      2'h0
`define ECD_SRC_SLOW        2'h1
`define ECD_SRC_FAST_A      2'h2
`define ECD_SRC_RSVD        2'h3

// Divider exponent offsets (ratio is 1 / 2**exponent)
`define ECD_TCLK_FAST_BASE  4'h7
`define ECD_DCLK_FAST_BASE  4'h2
`define ECD_DCLK_FAST_MIN   3'h2
`define ECD_DCLK_FAST_MAX   3'h6
`define ECD_DCLK_SLOW_MAX   3'h3

// Status register bit positions
`define ECD_STAT_TCLK_BIT   0
`define ECD_STAT_DCLK_BIT   1

`endif

// file: test/ecd_clock_chk.sv
// Port checker for the display clock control block
`include "ecd_defs.vh"
module ecd_clock_chk (
    input logic        clock,         // System clock
    input logic        reset,         // Sync reset
    input logic [15:0] regAddr,       // Address
    input logic [7:0]  regWrData,     // Write data
    input logic        regWrStb,      // Write strobe
    input logic        regRdStb,      // Read strobe
    input logic [7:0]  regRdData,     // Read data
    input logic        fastOscB,      // Fast pin B
    input logic        fastOscA,      // Fast pin A
    input logic        slowOsc,       // Slow pin
    input logic        timingClkOut,  // Timing clock
    input logic        doublerClkOut  // Doubler clock
);
    logic [7:0] tReg_q;  // Timing shadow
    logic [7:0] dReg_q;  // Doubler shadow
    logic [2:0] dCode;   // Doubler ratio code
    logic       tOn;     // Timing may run
    logic       dOn;     // Doubler may run
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Shadows, so gating is judged from the bus alone
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            tReg_q <= 8'h00;
            dReg_q <= 8'h00;
        end
        else if (regWrStb && regAddr == `ECD_TCLK_OFFSET)
            tReg_q <= regWrData;
        else if (regWrStb && regAddr == `ECD_DCLK_OFFSET)
            dReg_q <= regWrData;
    end
    // Enabled and legal; reserved codes count as off
    assign dCode = dReg_q[6:4];
    assign tOn = tReg_q[0] && tReg_q[3:2] != 2'h3;
    assign dOn = dReg_q[0] && dReg_q[3:2] != 2'h3 && (dReg_q[3:2] == 2'h1
                 ? dCode <= 3'h3 : dCode >= 3'h2 && dCode <= 3'h6);
    tclk_off_low_a: assert property ((!tOn) [*3] |-> !timingClkOut)
        else $error("timing clock high while off");
    dclk_off_low_a: assert property ((!dOn) [*3] |-> !doublerClkOut)
        else $error("doubler clock high while off");
    rst_quiet_a: assert property ($fell(reset) |->
        !timingClkOut && !doublerClkOut && regRdData == 8'h00)
        else $error("outputs not quiet after reset");
    rd_idle_zero_a: assert property (!regRdStb |=> regRdData == 8'h00)
        else $error("read data outside its cycle");
    tclk_readback_a: assert property ((regWrStb && regAddr == 16'h5070)
        ##1 (regRdStb && regAddr == 16'h5070)
        |=> regRdData == ($past(regWrData, 2) & 8'h7D))
        else $error("timing register readback wrong");
    dclk_readback_a: assert property ((regWrStb && regAddr == 16'h5071)
        ##1 (regRdStb && regAddr == 16'h5071)
        |=> regRdData == ($past(regWrData, 2) & 8'h7D))
        else $error("doubler register readback wrong");
    unmapped_rd_a: assert property (regRdStb && regAddr[15:4] != 12'h507
        |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    stat_off_a: assert property ((!tOn && !dOn) [*3] ##0
        (regRdStb && regAddr == `ECD_STATUS_OFFSET) |=> regRdData == 8'h00)
        else $error("status shows a stopped clock running");
endmodule // ecd_clock_chk

bind ecd_clock_ctrl ecd_clock_chk i_ecd_clock_chk (
    .clock(clock), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .fastOscB(fastOscB), .fastOscA(fastOscA),
    .slowOsc(slowOsc), .timingClkOut(timingClkOut),
    .doublerClkOut(doublerClkOut));

// file: test/ecd_clock_ctrl_bench.sv
// Self-checking bench for the display clock control block
`include "ecd_defs.vh"
module ecd_clock_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { bit d; logic [7:0] v; int p; } ecd_case_t;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0]  regWrData = 8'h00;
    logic        regWrStb = 1'b0;
    logic        regRdStb = 1'b0;
    logic [7:0]  regRdData;
    logic        fastOscB = 1'b0;
    logic        fastOscA = 1'b0;
    logic        slowOsc = 1'b0;
    logic        timingClkOut;
    logic        doublerClkOut;
    logic [4:0]  oscCnt_q = 5'h00;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // Target, setting, period in clocks (0 means no clock)
    ecd_case_t   cases[12] = '{
        '{0, 8'h05, 8},    '{0, 8'h75, 1024}, '{0, 8'h01, 512},
        '{0, 8'h19, 1536}, '{1, 8'h21, 64},   '{1, 8'h35, 64},
        '{1, 8'h69, 1536}, '{0, 8'h0D, 0},    '{0, 8'h04, 0},
        '{1, 8'h11, 0},    '{1, 8'h45, 0},    '{1, 8'h2D, 0}};

    ecd_clock_ctrl i_ecd_clock_ctrl (
        .clock(clock), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .fastOscB(fastOscB), .fastOscA(fastOscA),
        .slowOsc(slowOsc), .timingClkOut(timingClkOut),
        .doublerClkOut(doublerClkOut));

    // 40 MHz clock
    initial
    begin
        forever #12.5 clock = ~clock;
    end

    // Oscillators of 4, 6 and 8 clocks; all well under half the clock rate
    always @(posedge clock)
    begin
        oscCnt_q <= (oscCnt_q == 5'h17) ? 5'h00 : oscCnt_q + 5'h01;
        fastOscB <= oscCnt_q[1];
        slowOsc  <= oscCnt_q[2];
        if (oscCnt_q % 3 == 2)
            fastOscA <= ~fastOscA;
    end

    // Hang guard, well above the longest expected run
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] s, input logic [31:0] e,
                         input string what);
        total_checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", what, e, s);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clock);
        regWrStb  <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e,
                      input string what);
        @(posedge clock);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge clock);
        regRdStb <= 1'b0;
        #1;
        check(regRdData, e, what);
    endtask

    // Write then read back with no gap between the strobes
    task automatic wrrd(input logic [15:0] a, input logic [7:0] d,
                        input logic [7:0] e, input string what);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clock);
        regWrStb  <= 1'b0;
        regRdStb  <= 1'b1;
        @(posedge clock);
        regRdStb  <= 1'b0;
        #1;
        check(regRdData, e, what);
    endtask

    // Program one setting, then time two rises of the chosen output
    task automatic meas(input ecd_case_t c);
        int   n = 0;
        int   k = 0;
        logic p = 1'b1;
        logic o;
        wr(`ECD_TCLK_OFFSET, 8'h00);
        wr(`ECD_DCLK_OFFSET, 8'h00);
        wr(c.d ? `ECD_DCLK_OFFSET : `ECD_TCLK_OFFSET, c.v);
        while (k < 2 && n < (c.p > 0 ? 20000 : 300))
        begin
            @(posedge clock);
            #1;
            o = c.d ? doublerClkOut : timingClkOut;
            if (o === 1'b1 && p === 1'b0)
                k++;
            if (o === 1'b1 && p === 1'b0 && k == 1)
                n = 0;
            p = o;
            n++;
        end
        check(c.p > 0 ? n - 1 : k, c.p, "period");
        rd(`ECD_STATUS_OFFSET, c.p == 0 ? 8'h00 : (c.d ? 8'h02 : 8'h01),
           "status");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reset, register map, then every source with sample ratios and refusals
    initial
    begin
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        rd(`ECD_TCLK_OFFSET, 8'h00, "tclk reset");
        rd(`ECD_DCLK_OFFSET, 8'h00, "dclk reset");
        rd(`ECD_STATUS_OFFSET, 8'h00, "status reset");
        wrrd(`ECD_TCLK_OFFSET, 8'hFF, 8'h7D, "tclk rw");
        wrrd(`ECD_DCLK_OFFSET, 8'hFE, 8'h7C, "dclk rw");
        wrrd(16'h5072, 8'hFF, 8'h00, "unmapped");
        foreach (cases[i])
            meas(cases[i]);
        end_of_test();
    end
endmodule // ecd_clock_ctrl_bench
